// ===== pkg/rx_sig_err_pkg.sv
/*
 Constants for the receive signalling and error counter bank: register
 indices, field positions, reset values and table geometry.
 Assumes a word-addressed view: the byte address is four times the index.
*/
package rx_sig_err_pkg;
   localparam int MAX_PORTS = 8;
   localparam int ADDR_W = 14;
   localparam int PORT_LSB = 11;
   localparam int REG_W = 9;
   localparam int CNT_W = 16;
   localparam int NUM_CNT = 4;
   localparam int NIB_CHANNELS = 32;
   localparam int IRQ_W = 5;

   // Per-port register indices; port n adds n times 200h to the index
   localparam logic [11:0] PORT_STRIDE = 12'h200;
   localparam logic [REG_W-1:0] SIG_FIRST = 9'h040;
   localparam logic [REG_W-1:0] SIG_LAST = 9'h04f;
   localparam logic [REG_W-1:0] LINE_CODE_VIOL_COUNT_HI = 9'h050;
   localparam logic [REG_W-1:0] LINE_CODE_VIOL_COUNT_LO = 9'h051;
   localparam logic [REG_W-1:0] PATH_CODE_VIOL_COUNT_HI = 9'h052;
   localparam logic [REG_W-1:0] PATH_CODE_VIOL_COUNT_LO = 9'h053;
   localparam logic [REG_W-1:0] FRAMES_OUT_OF_SYNC_COUNT_HI = 9'h054;
   localparam logic [REG_W-1:0] FRAMES_OUT_OF_SYNC_COUNT_LO = 9'h055;
   localparam logic [REG_W-1:0] EBIT_ERROR_COUNT_HI = 9'h056;
   localparam logic [REG_W-1:0] EBIT_ERROR_COUNT_LO = 9'h057;
   localparam logic [REG_W-1:0] PORT_CTRL = 9'h070;
   localparam logic [REG_W-1:0] IRQ_STATUS = 9'h071;
   localparam logic [REG_W-1:0] IRQ_ENABLE = 9'h072;
   localparam logic [REG_W-1:0] IRQ_CLEAR = 9'h073;

   // Port control fields
   localparam int CTRL_E1_BIT = 0;
   localparam int CTRL_ESF_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Counter kinds, also interrupt bit positions
   localparam int CNT_LCV = 0;
   localparam int CNT_PCV = 1;
   localparam int CNT_FOS = 2;
   localparam int CNT_EBIT = 3;
   localparam int IRQ_SIG_BIT = 4;

   // Signalling table geometry
   localparam logic [4:0] T1_HI_OFS = 5'h01;
   localparam logic [4:0] T1_LO_OFS = 5'h0d;
   localparam logic [4:0] E1_LO_OFS = 5'h0f;
   localparam logic [3:0] T1_SIG_REGS = 4'hc;
   localparam logic [4:0] T1_LAST_CH = 5'h18;
   localparam logic [4:0] E1_LAST_CH = 5'h1e;
   localparam logic [3:0] E1_SPARE_NIB = 4'h0;

   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [3:0] NIB_RESET = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
endpackage

// ===== design/rx_sig_err_bank.sv
/*
 Receive signalling registers and error counters for up to eight ports,
 reached as a classic Wishbone slave with 32-bit data, byte registers in
 the low lane. Assumes signalling, sync state and error events arrive
 synchronous to clk_sys_in from the framer core.
*/
`timescale 1ns/1ps
module rx_sig_err_bank #(
   parameter int NUM_PORTS = 8
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [rx_sig_err_pkg::ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic sig_valid_in,
   input wire logic [2:0] sig_port_in,
   input wire logic [4:0] sig_chan_in,
   input wire logic [3:0] sig_abcd_in,
   input wire logic [7:0] loss_of_frame_sync_in,
   input wire logic [7:0] line_code_viol_evt_in,
   input wire logic [7:0] path_code_viol_evt_in,
   input wire logic [7:0] frames_out_of_sync_evt_in,
   input wire logic [7:0] ebit_err_evt_in,
   output logic irq_out
);
   // The port field of the address has room for eight ports only
   if (NUM_PORTS < 1 || NUM_PORTS > rx_sig_err_pkg::MAX_PORTS) begin : g_bad_ports
      $error("NUM_PORTS must lie between 1 and 8");
   end

   logic [3:0] sig_r [NUM_PORTS][rx_sig_err_pkg::NIB_CHANNELS];
   logic [rx_sig_err_pkg::CNT_W-1:0] cnt_r [NUM_PORTS][rx_sig_err_pkg::NUM_CNT];
   logic [1:0] ctrl_r [NUM_PORTS];
   logic [rx_sig_err_pkg::IRQ_W-1:0] irq_status_r [NUM_PORTS];
   logic [rx_sig_err_pkg::IRQ_W-1:0] irq_enable_r [NUM_PORTS];
   logic ack_r;
   logic [31:0] dat_r;
   logic irq_r;

   logic [2:0] port_sel;
   logic [rx_sig_err_pkg::REG_W-1:0] reg_sel;
   logic port_ok;
   logic req_go;
   logic wr_go;
   logic [7:0] rd_byte;
   logic [rx_sig_err_pkg::REG_W-1:0] reg_diff;
   logic [3:0] sig_row;
   logic [1:0] cnt_kind;
   logic [rx_sig_err_pkg::CNT_W-1:0] cnt_val;
   logic sig_e1;
   logic sig_esf;
   logic sig_chan_ok;
   logic [3:0] sig_nib;
   logic irq_nxt;
   logic [rx_sig_err_pkg::NUM_CNT-1:0] cnt_evt [NUM_PORTS];
   logic [NUM_PORTS-1:0] cnt_clr;

   // Port in the top index bits, register index below, byte address is index times four
   assign port_sel = wb_adr_in[rx_sig_err_pkg::ADDR_W-1:rx_sig_err_pkg::PORT_LSB];
   assign reg_sel = wb_adr_in[rx_sig_err_pkg::PORT_LSB-1:2];
   assign port_ok = (32'(port_sel) < 32'(NUM_PORTS));
   // Only the first cycle of a request counts, so a held write acts once
   assign req_go = wb_cyc_in & wb_stb_in & ~ack_r;
   assign wr_go = req_go & wb_we_in & wb_sel_in[0] & port_ok;

   // Read decode; reads have no side effects, so a retried read is harmless
   always_comb begin
      rd_byte = 8'h00;
      reg_diff = 9'h000;
      sig_row = 4'h0;
      cnt_kind = 2'h0;
      cnt_val = rx_sig_err_pkg::CNT_RESET;
      if (port_ok) begin
         if (reg_sel >= rx_sig_err_pkg::SIG_FIRST && reg_sel <= rx_sig_err_pkg::SIG_LAST) begin
            reg_diff = reg_sel - rx_sig_err_pkg::SIG_FIRST;
            sig_row = reg_diff[3:0];
            if (ctrl_r[port_sel][rx_sig_err_pkg::CTRL_E1_BIT]) begin
               if (sig_row == 4'h0) begin
                  rd_byte = {rx_sig_err_pkg::E1_SPARE_NIB, sig_r[port_sel][0]};
               end else begin
                  rd_byte = {sig_r[port_sel][{1'b0, sig_row}],
                             sig_r[port_sel][{1'b0, sig_row} + rx_sig_err_pkg::E1_LO_OFS]};
               end
            end else if (sig_row < rx_sig_err_pkg::T1_SIG_REGS) begin
               rd_byte = {sig_r[port_sel][{1'b0, sig_row} + rx_sig_err_pkg::T1_HI_OFS],
                          sig_r[port_sel][{1'b0, sig_row} + rx_sig_err_pkg::T1_LO_OFS]};
            end
         end else if (reg_sel >= rx_sig_err_pkg::LINE_CODE_VIOL_COUNT_HI &&
                      reg_sel <= rx_sig_err_pkg::EBIT_ERROR_COUNT_LO) begin
            // Pairs of byte registers: even index high byte, odd index low byte
            reg_diff = reg_sel - rx_sig_err_pkg::LINE_CODE_VIOL_COUNT_HI;
            cnt_kind = reg_diff[2:1];
            cnt_val = cnt_r[port_sel][cnt_kind];
            // E-bit count exists in E1 only and reads zero otherwise
            if (32'(cnt_kind) == rx_sig_err_pkg::CNT_EBIT &&
                !ctrl_r[port_sel][rx_sig_err_pkg::CTRL_E1_BIT]) begin
               cnt_val = rx_sig_err_pkg::CNT_RESET;
            end
            rd_byte = reg_diff[0] ? cnt_val[7:0] : cnt_val[15:8];
         end else if (reg_sel == rx_sig_err_pkg::PORT_CTRL) begin
            rd_byte = {6'h00, ctrl_r[port_sel]};
         end else if (reg_sel == rx_sig_err_pkg::IRQ_STATUS) begin
            rd_byte = {3'h0, irq_status_r[port_sel]};
         end else if (reg_sel == rx_sig_err_pkg::IRQ_ENABLE) begin
            rd_byte = {3'h0, irq_enable_r[port_sel]};
         end
      end
   end

   // Bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req_go;
         if (req_go && !wb_we_in) begin
            dat_r <= {24'h000000, rd_byte};
         end
      end
   end

   // Incoming signalling nibble for the addressed port
   always_comb begin
      sig_e1 = 1'b0;
      sig_esf = 1'b0;
      sig_chan_ok = 1'b0;
      sig_nib = sig_abcd_in;
      if (32'(sig_port_in) < 32'(NUM_PORTS)) begin
         sig_e1 = ctrl_r[sig_port_in][rx_sig_err_pkg::CTRL_E1_BIT];
         sig_esf = ctrl_r[sig_port_in][rx_sig_err_pkg::CTRL_ESF_BIT];
         if (sig_e1) begin
            sig_chan_ok = (sig_chan_in <= rx_sig_err_pkg::E1_LAST_CH);
         end else begin
            sig_chan_ok = (sig_chan_in != 5'h00) && (sig_chan_in <= rx_sig_err_pkg::T1_LAST_CH);
         end
         // Freeze while sync is lost so software sees the last good pattern
         if (loss_of_frame_sync_in[sig_port_in]) begin
            sig_chan_ok = 1'b0;
         end
      end
      if (!sig_e1 && !sig_esf) begin
         sig_nib = {sig_abcd_in[3:2], sig_abcd_in[3:2]};
      end
   end

   // Signalling store
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int c = 0; c < rx_sig_err_pkg::NIB_CHANNELS; c++) begin
               sig_r[p][c] <= rx_sig_err_pkg::NIB_RESET;
            end
         end
      end else if (sig_valid_in && sig_chan_ok) begin
         sig_r[sig_port_in][sig_chan_in] <= sig_nib;
      end
   end

   // Port control; the clear bit is a pulse and is not stored
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            ctrl_r[p] <= rx_sig_err_pkg::CTRL_RESET;
         end
      end else if (wr_go && reg_sel == rx_sig_err_pkg::PORT_CTRL) begin
         ctrl_r[port_sel] <= wb_dat_in[1:0];
      end
   end

   // Per-port event and clear strobes for the counters
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         cnt_clr[p] = clr_of(p);
         for (int k = 0; k < rx_sig_err_pkg::NUM_CNT; k++) begin
            cnt_evt[p][k] = evt_of(p, k);
         end
      end
   end

   // One counter per port and kind; ports past NUM_PORTS have none and read zero
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      for (genvar k = 0; k < rx_sig_err_pkg::NUM_CNT; k++) begin : g_cnt
         sat_event_counter #(
            .WIDTH(rx_sig_err_pkg::CNT_W)
         ) i_cnt (
            .clk_sys_in(clk_sys_in),
            .reset_in(reset_in),
            .evt_in(cnt_evt[p][k]),
            .clr_in(cnt_clr[p]),
            .count_out(cnt_r[p][k])
         );
      end
   end

   function automatic logic clr_of(input int p);
      clr_of = wr_go && 32'(port_sel) == p && reg_sel == rx_sig_err_pkg::PORT_CTRL &&
               wb_dat_in[rx_sig_err_pkg::CTRL_CLR_BIT];
   endfunction

   function automatic logic evt_of(input int p, input int k);
      evt_of = 1'b0;
      case (k)
         rx_sig_err_pkg::CNT_LCV: evt_of = line_code_viol_evt_in[p];
         rx_sig_err_pkg::CNT_PCV: evt_of = path_code_viol_evt_in[p];
         rx_sig_err_pkg::CNT_FOS: evt_of = frames_out_of_sync_evt_in[p];
         rx_sig_err_pkg::CNT_EBIT: evt_of = ebit_err_evt_in[p] & ctrl_r[p][rx_sig_err_pkg::CTRL_E1_BIT];
         default: evt_of = 1'b0;
      endcase
   endfunction

   // Sticky interrupt status; a new event wins over a clear in the same cycle
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_irq
      logic [rx_sig_err_pkg::IRQ_W-1:0] set_v;
      logic [rx_sig_err_pkg::IRQ_W-1:0] clr_v;
      logic en_wr;

      // Clears and enable writes act once, on the edge that takes the write
      always_comb begin
         set_v = rx_sig_err_pkg::IRQ_RESET;
         for (int k = 0; k < rx_sig_err_pkg::NUM_CNT; k++) begin
            set_v[k] = cnt_evt[p][k];
         end
         set_v[rx_sig_err_pkg::IRQ_SIG_BIT] = sig_valid_in && sig_chan_ok &&
                                              32'(sig_port_in) == p;
         clr_v = rx_sig_err_pkg::IRQ_RESET;
         en_wr = 1'b0;
         if (wr_go && 32'(port_sel) == p) begin
            if (reg_sel == rx_sig_err_pkg::IRQ_CLEAR) begin
               clr_v = wb_dat_in[rx_sig_err_pkg::IRQ_W-1:0];
            end
            en_wr = (reg_sel == rx_sig_err_pkg::IRQ_ENABLE);
         end
      end

      always_ff @(posedge clk_sys_in) begin
         if (reset_in) begin
            irq_status_r[p] <= rx_sig_err_pkg::IRQ_RESET;
            irq_enable_r[p] <= rx_sig_err_pkg::IRQ_RESET;
         end else begin
            irq_status_r[p] <= (irq_status_r[p] & ~clr_v) | set_v;
            if (en_wr) begin
               irq_enable_r[p] <= wb_dat_in[rx_sig_err_pkg::IRQ_W-1:0];
            end
         end
      end
   end

   always_comb begin
      irq_nxt = 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         irq_nxt = irq_nxt | (|(irq_status_r[p] & irq_enable_r[p]));
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = dat_r;
   assign irq_out = irq_r;
endmodule

// One saturating event counter; an event in a clear cycle is counted from zero
module sat_event_counter #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic evt_in,
   input wire logic clr_in,
   output logic [WIDTH-1:0] count_out
);
   localparam logic [WIDTH-1:0] ZERO = WIDTH'(rx_sig_err_pkg::CNT_RESET);
   localparam logic [WIDTH-1:0] STEP = WIDTH'(1);
   // All ones is the saturation point whatever the width
   localparam logic [WIDTH-1:0] TOP = {WIDTH{1'b1}};

   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;

   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   // Saturate rather than wrap so a busy line never reads low
   always_comb begin
      count_nxt = count_r;
      if (evt_in && clr_in) begin
         count_nxt = STEP;
      end else if (evt_in) begin
         if (count_r != TOP) begin
            count_nxt = count_r + STEP;
         end
      end else if (clr_in) begin
         count_nxt = ZERO;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         count_r <= ZERO;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count_out = count_r;
endmodule

// ===== tb/rx_sig_err_assertions.sv
/*
 Checker for the signalling and error counter bank: bus answer, read data
 and interrupt timing. Assumes it is bound to the bank's top ports.
*/
`timescale 1ns/1ps
module rx_sig_err_assertions (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [rx_sig_err_pkg::ADDR_W-1:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic sig_valid_in,
   input wire logic [7:0] line_code_viol_evt_in,
   input wire logic [7:0] path_code_viol_evt_in,
   input wire logic [7:0] frames_out_of_sync_evt_in,
   input wire logic [7:0] ebit_err_evt_in,
   input wire logic irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   logic take;
   logic cause;
   assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign cause = sig_valid_in || (take && wb_we_in) || (|{line_code_viol_evt_in,
      path_code_viol_evt_in, frames_out_of_sync_evt_in, ebit_err_evt_in});
   sequence rd_taken;
      take && !wb_we_in;
   endsequence
   sequence answered;
      wb_ack_out ##1 !wb_ack_out;
   endsequence
   a_ack_after_take: assert property (take |=> answered)
      else $error("ack not a single pulse after request");
   a_ack_has_req: assert property (wb_ack_out |-> $past(take))
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_dat_holds: assert property (!(take && !wb_we_in) |=> $stable(wb_dat_out))
      else $error("read data changed without read");
   a_unmapped_zero: assert property (
      rd_taken ##0 (wb_adr_in[10:2] inside {[9'h058:9'h06f]}) |=> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_irq_rise_cause: assert property ($rose(irq_out) |-> $past(cause, 2) || $past(cause))
      else $error("interrupt rose without cause");
   a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(take && wb_we_in, 2)
      || $past(take && wb_we_in))
      else $error("interrupt fell without write");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset_in |=> !wb_ack_out && !irq_out && wb_dat_out == 32'h0)
      else $error("outputs active in reset");
endmodule

// ===== tb/testbench.sv
/*
 Self-checking bench for the signalling and error counter bank.
 Assumes the package is compiled first; drives every port itself.
*/
`timescale 1ns/1ps
module testbench;
   logic clk_sys_in, reset_in, cyc, stb, we, sv, ack, irq;
   logic [13:0] adr;
   logic [3:0] sel, sa;
   logic [31:0] wdat, rdat, got;
   logic [2:0] sp;
   logic [4:0] sc;
   logic [7:0] lof;
   logic [3:0][7:0] ev;
   int error_cnt, comparisons;
   rx_sig_err_bank #(.NUM_PORTS(8)) i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .sig_valid_in(sv),
      .sig_port_in(sp), .sig_chan_in(sc), .sig_abcd_in(sa), .loss_of_frame_sync_in(lof),
      .line_code_viol_evt_in(ev[0]), .path_code_viol_evt_in(ev[1]),
      .frames_out_of_sync_evt_in(ev[2]), .ebit_err_evt_in(ev[3]), .irq_out(irq));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   task automatic report_and_stop;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Sampling right after the edge sees pre-edge values, as the master would
   task automatic acc(input logic w, input logic [2:0] p, input logic [8:0] i,
      input logic [7:0] d);
      int n;
      @(posedge clk_sys_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {p, i, 2'b00};
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         $display("[FAIL] %0t no bus answer", $time);
         error_cnt++;
         report_and_stop;
      end
   endtask
   task automatic rd(input logic [2:0] p, input logic [8:0] i, input logic [7:0] e);
      acc(1'b0, p, i, 8'h00);
      chk(got, {24'h0, e});
   endtask
   // Back-to-back pulses: each high cycle must count once
   task automatic evt(input int k, input logic [7:0] m, input int n);
      @(posedge clk_sys_in);
      ev[k] <= m;
      repeat (n) @(posedge clk_sys_in);
      ev[k] <= 8'h00;
   endtask
   task automatic sg(input logic [2:0] p, input logic [4:0] c, input logic [3:0] a);
      @(posedge clk_sys_in);
      sv <= 1'b1;
      sp <= p;
      sc <= c;
      sa <= a;
      @(posedge clk_sys_in);
      sv <= 1'b0;
   endtask
   task automatic irq_chk(input logic e);
      repeat (3) @(posedge clk_sys_in);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   initial begin
      {reset_in, cyc, stb, we, sv, adr, wdat, sp, sc, sa, lof, ev} = '0;
      reset_in = 1'b1;
      sel = 4'hf;
      error_cnt = 0;
      comparisons = 0;
      repeat (16) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      rd(7, 9'h055, 8'h00);
      evt(0, 8'h01, 3);
      rd(0, 9'h050, 8'h00);
      rd(0, 9'h051, 8'h03);
      evt(1, 8'h80, 2);
      rd(7, 9'h053, 8'h02);
      rd(0, 9'h053, 8'h00);
      evt(2, 8'h04, 260);
      rd(2, 9'h054, 8'h01);
      rd(2, 9'h055, 8'h04);
      evt(3, 8'h01, 1);
      rd(0, 9'h057, 8'h00);
      acc(1'b1, 0, 9'h070, 8'h01);
      evt(3, 8'h01, 5);
      rd(0, 9'h056, 8'h00);
      rd(0, 9'h057, 8'h05);
      acc(1'b1, 0, 9'h070, 8'h05);
      rd(0, 9'h057, 8'h00);
      rd(0, 9'h051, 8'h00);
      rd(0, 9'h070, 8'h01);
      acc(1'b1, 1, 9'h070, 8'h02);
      sg(1, 1, 4'ha);
      sg(1, 13, 4'h5);
      sg(1, 12, 4'h3);
      sg(1, 24, 4'hc);
      rd(1, 9'h040, 8'ha5);
      rd(1, 9'h04b, 8'h3c);
      rd(1, 9'h04c, 8'h00);
      sg(2, 2, 4'hb);
      sg(2, 14, 4'h6);
      rd(2, 9'h041, 8'ha5);
      acc(1'b1, 3, 9'h070, 8'h01);
      sg(3, 0, 4'hb);
      sg(3, 1, 4'h9);
      sg(3, 16, 4'h6);
      sg(3, 15, 4'h3);
      sg(3, 30, 4'he);
      rd(3, 9'h040, 8'h0b);
      rd(3, 9'h041, 8'h96);
      rd(3, 9'h04f, 8'h3e);
      lof <= 8'h08;
      sg(3, 1, 4'h1);
      rd(3, 9'h041, 8'h96);
      lof <= 8'h00;
      sg(3, 1, 4'h1);
      rd(3, 9'h041, 8'h16);
      acc(1'b1, 4, 9'h072, 8'h01);
      evt(1, 8'h10, 1);
      irq_chk(1'b0);
      rd(4, 9'h071, 8'h02);
      evt(0, 8'h10, 1);
      irq_chk(1'b1);
      acc(1'b1, 4, 9'h073, 8'h03);
      irq_chk(1'b0);
      rd(4, 9'h071, 8'h00);
      acc(1'b1, 4, 9'h051, 8'h55);
      rd(4, 9'h051, 8'h01);
      acc(1'b1, 4, 9'h060, 8'h55);
      rd(4, 9'h060, 8'h00);
      report_and_stop;
   end
endmodule
bind rx_sig_err_bank rx_sig_err_assertions i_chk (.clk_sys_in(clk_sys_in),
   .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .sig_valid_in(sig_valid_in), .line_code_viol_evt_in(line_code_viol_evt_in),
   .path_code_viol_evt_in(path_code_viol_evt_in),
   .frames_out_of_sync_evt_in(frames_out_of_sync_evt_in),
   .ebit_err_evt_in(ebit_err_evt_in), .irq_out(irq_out));
